// file: common/pscfg_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * serial-port and PLL feedback register bank. Assumes 8-bit registers and a
 * 13-bit register address space reached through the serial control port.
 */
// Behaviour
// - Port configuration writes act at once, no update strobe needed.
// - Bit 4 selects instruction length: 16 bits when set, 8 when clear.
// - Soft reset bit set returns internal registers to defaults.
// - Bit 6 set shifts data LSB first; clear shifts MSB first.
// - In LSB-first mode address bits and address stepping follow that order.
// - Bit 7 set floats readback pin and returns data on bidirectional pin.
// - Swallow count is 6 bits in bits 5:0, upper bits unused.
// - Feedback count is 13 bits: 12:8 in one register, 7:0 next.
// - 2-bit code picks 3/6/12/24 PFD cycle lock delay; enable defaults off.
`ifndef PSCFG_REGS_SVH
`define PSCFG_REGS_SVH

`define PSC_ADDR_W            13
`define PSC_NUM_REGS          9
`define PSC_ADDR_SETUP        13'h0000
`define PSC_ADDR_SWALLOW      13'h0004
`define PSC_ADDR_FB_UPPER     13'h0005
`define PSC_ADDR_FB_LOWER     13'h0006
`define PSC_ADDR_REF_LOSS     13'h0007
`define PSC_ADDR_PUMP         13'h0008

`define PSC_SETUP_LONG_BIT    4
`define PSC_SETUP_SRST_BIT    5
`define PSC_SETUP_LSB_BIT     6
`define PSC_SETUP_BIDIR_BIT   7
`define PSC_REF_LOSS_EN_BIT   2
`define PSC_REF_LOSS_DLY_LSB  5

`define PSC_MASK_SETUP        8'hF0
`define PSC_MASK_SWALLOW      8'h3F
`define PSC_MASK_FB_UPPER     8'h1F
`define PSC_MASK_FB_LOWER     8'hFF
`define PSC_MASK_REF_LOSS     8'h64
`define PSC_MASK_PUMP         8'h03
`define PSC_MASK_NONE         8'h00

`define PSC_RST_SETUP         8'h10
`define PSC_RST_OTHER         8'h00

`define PSC_LONG_INSTR_BITS   5'h10
`define PSC_SHORT_INSTR_BITS  5'h08
`define PSC_LOR_BASE_CYCLES   5'h03

`endif

// file: common/pscfg_pkg.sv
/*
 * Types shared by the register bank files. Assumes the constants of
 * pscfg_regs.svh for widths.
 */
`include "pscfg_regs.svh"

package pscfg_pkg;

	typedef enum logic [1:0] {
		PSCFG_CP_TRISTATE,
		PSCFG_CP_PUMP_UP,
		PSCFG_CP_PUMP_DOWN,
		PSCFG_CP_NORMAL
	} pscfg_cp_mode_t;

	typedef struct packed {
		logic           readback_pin_disable;
		logic           lsb_first;
		logic           soft_reset;
		logic           long_instr;
		logic [5:0]     swallow_count;
		logic [12:0]    feedback_count;
		logic           ref_loss_enable;
		logic [1:0]     ref_loss_delay;
		pscfg_cp_mode_t cp_mode;
	} pscfg_cfg_t;

	typedef struct packed {
		logic sdio_o;
		logic sdio_oe;
		logic readback_o;
		logic readback_oe;
	} pscfg_pins_t;

endpackage

// file: rtl/pscfg_sync.sv
/*
 * Two-flop synchroniser, one stage pair per bit. Assumes asynchronous
 * inputs that are slow against clk_sys.
 */
`timescale 1ns/100ps

module pscfg_sync #(
	parameter int W = 3
) (
	input  wire logic         clk_sys, // System clock
	input  wire logic         rst_n,   // Async reset, active low
	input  wire logic [W-1:0] async_i, // Pin levels
	output logic      [W-1:0] sync_o   // Synchronised levels
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_q;
			logic stab_q;
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					meta_q <= 1'b0;
					stab_q <= 1'b0;
				end else begin
					meta_q <= async_i[i];
					stab_q <= meta_q;
				end
			end
			assign sync_o[i] = stab_q;
		end
	endgenerate

endmodule

// file: rtl/pscfg_regfile.sv
/*
 * Register storage for the port setup and PLL feedback registers. Assumes
 * one write and one read per clk_sys cycle from the serial engine.
 */
`timescale 1ns/100ps
`include "pscfg_regs.svh"

module pscfg_regfile (
	input  wire logic                    clk_sys, // System clock
	input  wire logic                    rst_n,   // Async reset, active low
	input  wire logic                    wr_en,   // Write strobe
	input  wire logic [`PSC_ADDR_W-1:0]  wr_addr, // Write address
	input  wire logic [7:0]              wr_data, // Write byte
	input  wire logic [`PSC_ADDR_W-1:0]  rd_addr, // Read address
	output logic      [7:0]              rd_data, // Read byte
	output pscfg_pkg::pscfg_cfg_t        cfg      // Decoded settings
);
	import pscfg_pkg::*;

	localparam logic [7:0] MASK [0:`PSC_NUM_REGS-1] = '{`PSC_MASK_SETUP,
		`PSC_MASK_NONE, `PSC_MASK_NONE, `PSC_MASK_NONE, `PSC_MASK_SWALLOW,
		`PSC_MASK_FB_UPPER, `PSC_MASK_FB_LOWER, `PSC_MASK_REF_LOSS,
		`PSC_MASK_PUMP};

	logic [7:0] regs_q [0:`PSC_NUM_REGS-1];
	wire        soft_rst = regs_q[0][`PSC_SETUP_SRST_BIT];
	wire        rd_hit   = (rd_addr < `PSC_ADDR_W'(`PSC_NUM_REGS));

	genvar i;
	generate
		for (i = 0; i < `PSC_NUM_REGS; i++) begin : g_reg
			localparam logic [7:0] RST = (i == 0) ? `PSC_RST_SETUP : `PSC_RST_OTHER;
			wire hit = wr_en && (wr_addr == `PSC_ADDR_W'(i));
			// Setup register is left out of soft reset so the host can release it
			wire hold = (i != 0) && soft_rst;
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n)
					regs_q[i] <= RST;
				else if (hold)
					regs_q[i] <= RST;
				else if (hit)
					regs_q[i] <= wr_data & MASK[i];
			end
		end
	endgenerate

	assign rd_data = rd_hit ? regs_q[rd_addr[3:0]] : 8'h00;

	assign cfg.readback_pin_disable = regs_q[0][`PSC_SETUP_BIDIR_BIT];
	assign cfg.lsb_first            = regs_q[0][`PSC_SETUP_LSB_BIT];
	assign cfg.soft_reset           = soft_rst;
	assign cfg.long_instr           = regs_q[0][`PSC_SETUP_LONG_BIT];
	assign cfg.swallow_count        = regs_q[4][5:0];
	assign cfg.feedback_count       = {regs_q[5][4:0], regs_q[6]};
	assign cfg.ref_loss_enable      = regs_q[7][`PSC_REF_LOSS_EN_BIT];
	assign cfg.ref_loss_delay       = regs_q[7][`PSC_REF_LOSS_DLY_LSB +: 2];
	assign cfg.cp_mode              = pscfg_cp_mode_t'(regs_q[8][1:0]);

endmodule

// file: rtl/pscfg_top.sv
/*
 * Serial control port and register bank for the port setup and PLL
 * feedback settings. Select, serial clock and data arrive from an outside
 * host and are sampled by clk_sys, which must run at least eight times
 * faster than the serial clock.
 */
`timescale 1ns/100ps
`include "pscfg_regs.svh"

module pscfg_top (
	input  wire logic              clk_sys,                // System clock, 10 MHz
	input  wire logic              rst_n,                  // Async reset, active low
	input  wire logic              serial_select_n,        // Port select, active low
	input  wire logic              serial_clk,             // Serial clock from host
	input  wire logic              sdio_i,                 // Bidirectional data, input
	output logic                   sdio_o,                 // Bidirectional data, output
	output logic                   sdio_oe,                // Bidirectional data, enable
	output logic                   serial_readback_pin_o,  // Readback pin, output
	output logic                   serial_readback_pin_oe, // Readback pin, enable
	output pscfg_pkg::pscfg_cfg_t  cfg_o,                  // Live register settings
	output logic [4:0]             ref_loss_delay_cycles,  // Lock delay in PFD cycles
	output logic                   cp_pump_up,             // Pump sources current
	output logic                   cp_pump_down,           // Pump sinks current
	output logic                   cp_pfd_driven,          // Pump follows detector
	output logic                   cp_tristate             // Pump output floats
);
	import pscfg_pkg::*;

	typedef enum logic [1:0] {
		PSCFG_ST_INSTR,
		PSCFG_ST_WRITE,
		PSCFG_ST_READ,
		PSCFG_ST_DONE
	} pscfg_state_t;

	// Pin synchronisation
	logic [2:0] pins_s;
	pscfg_sync #(.W(3)) u_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.async_i ({serial_select_n, serial_clk, sdio_i}),
		.sync_o  (pins_s)
	);

	wire select_n_s = pins_s[2];
	wire sclk_s     = pins_s[1];
	wire sdata_s    = pins_s[0];

	logic sclk_prev_q;
	wire  sclk_rise = sclk_s & ~sclk_prev_q;
	wire  sclk_fall = ~sclk_s & sclk_prev_q;

	// Serial engine state
	pscfg_state_t              state_q,    state_d;
	logic [15:0]               ishift_q,   ishift_d;
	logic [4:0]                icount_q,   icount_d;
	logic [7:0]                dshift_q,   dshift_d;
	logic [2:0]                bitcnt_q,   bitcnt_d;
	logic [`PSC_ADDR_W-1:0]    addr_q,     addr_d;
	logic [1:0]                bytes_q,    bytes_d;
	logic                      stream_q,   stream_d;
	logic                      reload_q,   reload_d;
	logic                      out_bit_q,  out_bit_d;
	pscfg_pins_t               pins_q,     pins_d;

	// Register file
	pscfg_cfg_t                cfg;
	logic [7:0]                rd_data;
	logic                      wr_en;
	logic [7:0]                wr_data;

	pscfg_regfile u_regs (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.wr_en   (wr_en),
		.wr_addr (addr_q),
		.wr_data (wr_data),
		.rd_addr (addr_q),
		.rd_data (rd_data),
		.cfg     (cfg)
	);

	// Instruction decode
	wire        lsb_first  = cfg.lsb_first;
	wire [4:0]  instr_len  = cfg.long_instr ? `PSC_LONG_INSTR_BITS
	                                        : `PSC_SHORT_INSTR_BITS;
	// LSB-first shifts right so both orders land the word in the same layout
	wire [15:0] ishift_in  = lsb_first ? {sdata_s, ishift_q[15:1]}
	                                   : {ishift_q[14:0], sdata_s};
	wire [15:0] instr_word = cfg.long_instr ? ishift_in :
	                         lsb_first      ? {8'h00, ishift_in[15:8]}
	                                        : {8'h00, ishift_in[7:0]};
	wire        instr_read = cfg.long_instr ? instr_word[15] : instr_word[7];
	wire [1:0]  instr_len_code = cfg.long_instr ? instr_word[14:13] : instr_word[6:5];
	wire [`PSC_ADDR_W-1:0] instr_addr = cfg.long_instr ? instr_word[12:0]
	                                                   : {8'h00, instr_word[4:0]};
	wire        instr_last = (icount_q == instr_len - 5'h01);

	// Data path helpers
	wire [7:0]  dshift_in  = lsb_first ? {sdata_s, dshift_q[7:1]}
	                                   : {dshift_q[6:0], sdata_s};
	// Address walks upward in LSB-first order, downward otherwise
	wire [`PSC_ADDR_W-1:0] addr_step = lsb_first ? addr_q + `PSC_ADDR_W'(1)
	                                             : addr_q - `PSC_ADDR_W'(1);
	wire        byte_last  = (bitcnt_q == 3'h7);
	wire        xfer_last  = !stream_q && (bytes_q == 2'h0);
	wire [7:0]  rd_src     = reload_q ? rd_data : dshift_q;
	wire        rd_bit     = lsb_first ? rd_src[0] : rd_src[7];
	wire [7:0]  rd_shifted = lsb_first ? {1'b0, rd_src[7:1]} : {rd_src[6:0], 1'b0};

	assign wr_en   = (state_q == PSCFG_ST_WRITE) && sclk_rise && byte_last
	                 && !select_n_s;
	assign wr_data = dshift_in;

	always_comb begin
		state_d   = state_q;
		ishift_d  = ishift_q;
		icount_d  = icount_q;
		dshift_d  = dshift_q;
		bitcnt_d  = bitcnt_q;
		addr_d    = addr_q;
		bytes_d   = bytes_q;
		stream_d  = stream_q;
		reload_d  = reload_q;
		out_bit_d = out_bit_q;
		if (select_n_s) begin
			// Deselect aborts any frame; a partial byte is discarded
			state_d   = PSCFG_ST_INSTR;
			icount_d  = 5'h00;
			bitcnt_d  = 3'h0;
			reload_d  = 1'b0;
			out_bit_d = 1'b0;
		end else begin
			case (state_q)
				PSCFG_ST_INSTR: begin
					if (sclk_rise) begin
						ishift_d = ishift_in;
						icount_d = icount_q + 5'h01;
						if (instr_last) begin
							addr_d   = instr_addr;
							bytes_d  = instr_len_code;
							stream_d = (instr_len_code == 2'h3);
							bitcnt_d = 3'h0;
							reload_d = instr_read;
							state_d  = instr_read ? PSCFG_ST_READ : PSCFG_ST_WRITE;
						end
					end
				end
				PSCFG_ST_WRITE: begin
					if (sclk_rise) begin
						dshift_d = dshift_in;
						bitcnt_d = bitcnt_q + 3'h1;
						if (byte_last) begin
							addr_d  = addr_step;
							bytes_d = bytes_q - 2'h1;
							if (xfer_last)
								state_d = PSCFG_ST_DONE;
						end
					end
				end
				PSCFG_ST_READ: begin
					// Host samples on rising edges, so bits change on falling ones
					if (sclk_fall) begin
						out_bit_d = rd_bit;
						dshift_d  = rd_shifted;
						reload_d  = 1'b0;
					end else if (sclk_rise) begin
						bitcnt_d = bitcnt_q + 3'h1;
						if (byte_last) begin
							addr_d   = addr_step;
							bytes_d  = bytes_q - 2'h1;
							reload_d = 1'b1;
							if (xfer_last)
								state_d = PSCFG_ST_DONE;
						end
					end
				end
				PSCFG_ST_DONE: begin
					// Extra clocks past the byte count are ignored until deselect
					out_bit_d = 1'b0;
				end
				default: begin
					state_d = PSCFG_ST_INSTR;
				end
			endcase
		end
	end

	// Readback steering follows the live setup bit
	wire driving = (state_q == PSCFG_ST_READ) && !select_n_s;
	wire bidir   = cfg.readback_pin_disable;

	always_comb begin
		pins_d.sdio_o      = out_bit_d;
		pins_d.sdio_oe     = driving && bidir;
		pins_d.readback_o  = out_bit_d;
		pins_d.readback_oe = driving && !bidir;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q     <= PSCFG_ST_INSTR;
			sclk_prev_q <= 1'b0;
			ishift_q    <= 16'h0000;
			icount_q    <= 5'h00;
			dshift_q    <= 8'h00;
			bitcnt_q    <= 3'h0;
		end else begin
			state_q     <= state_d;
			sclk_prev_q <= sclk_s;
			ishift_q    <= ishift_d;
			icount_q    <= icount_d;
			dshift_q    <= dshift_d;
			bitcnt_q    <= bitcnt_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			addr_q    <= `PSC_ADDR_SETUP;
			bytes_q   <= 2'h0;
			stream_q  <= 1'b0;
			reload_q  <= 1'b0;
			out_bit_q <= 1'b0;
			pins_q    <= '0;
		end else begin
			addr_q    <= addr_d;
			bytes_q   <= bytes_d;
			stream_q  <= stream_d;
			reload_q  <= reload_d;
			out_bit_q <= out_bit_d;
			pins_q    <= pins_d;
		end
	end

	assign sdio_o                 = pins_q.sdio_o;
	assign sdio_oe                = pins_q.sdio_oe;
	assign serial_readback_pin_o  = pins_q.readback_o;
	assign serial_readback_pin_oe = pins_q.readback_oe;

	// PLL-facing decode, registered so outputs never glitch on a write
	wire [4:0] lor_cycles_d = `PSC_LOR_BASE_CYCLES << cfg.ref_loss_delay;
	wire       mode_up      = (cfg.cp_mode == PSCFG_CP_PUMP_UP);
	wire       mode_down    = (cfg.cp_mode == PSCFG_CP_PUMP_DOWN);
	wire       mode_normal  = (cfg.cp_mode == PSCFG_CP_NORMAL);
	wire       mode_tri     = (cfg.cp_mode == PSCFG_CP_TRISTATE);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cfg_o                 <= '0;
			ref_loss_delay_cycles <= `PSC_LOR_BASE_CYCLES;
			cp_pump_up            <= 1'b0;
			cp_pump_down          <= 1'b0;
			cp_pfd_driven         <= 1'b0;
			cp_tristate           <= 1'b1;
		end else begin
			cfg_o                 <= cfg;
			ref_loss_delay_cycles <= lor_cycles_d;
			cp_pump_up            <= mode_up;
			cp_pump_down          <= mode_down;
			cp_pfd_driven         <= mode_normal;
			cp_tristate           <= mode_tri;
		end
	end

endmodule

// file: test/pscfg_top_asserts.sv
/* Port checks for pscfg_top: pump and delay decode, pin enables, soft reset.
   Assumes it is bound to pscfg_top and sees only its ports. */
`timescale 1ns/100ps

module pscfg_top_asserts (
	input logic                  clk_sys,                // Clock
	input logic                  rst_n,                  // Reset, active low
	input logic                  serial_select_n,        // Select, active low
	input logic                  serial_clk,             // Serial clock
	input logic                  sdio_i,                 // Shared pin in
	input logic                  sdio_o,                 // Shared pin out
	input logic                  sdio_oe,                // Shared pin enable
	input logic                  serial_readback_pin_o,  // Readback out
	input logic                  serial_readback_pin_oe, // Readback enable
	input pscfg_pkg::pscfg_cfg_t cfg_o,                  // Settings
	input logic [4:0]            ref_loss_delay_cycles,  // Lock delay
	input logic                  cp_pump_up,             // Pump up
	input logic                  cp_pump_down,           // Pump down
	input logic                  cp_pfd_driven,          // Normal pump
	input logic                  cp_tristate             // Pump floats
);
	import pscfg_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire [3:0] cp_all = {cp_pump_up, cp_pump_down, cp_pfd_driven, cp_tristate};
	wire [3:0] cp_exp = {cfg_o.cp_mode == PSCFG_CP_PUMP_UP, cfg_o.cp_mode == PSCFG_CP_PUMP_DOWN,
		cfg_o.cp_mode == PSCFG_CP_NORMAL, cfg_o.cp_mode == PSCFG_CP_TRISTATE};
	// Two stable cycles allow the decode one register of lag
	property p_cp_decode;
		$stable(cfg_o.cp_mode) [*2] |-> cp_all == cp_exp;
	endproperty
	a_cp_decode: assert property (p_cp_decode) else $error("pump decode wrong");
	property p_cp_onehot;
		$onehot(cp_all);
	endproperty
	a_cp_onehot: assert property (p_cp_onehot) else $error("pump flags not one-hot");
	property p_lor_delay;
		$stable(cfg_o.ref_loss_delay) [*2] |-> ref_loss_delay_cycles == (5'h03 << cfg_o.ref_loss_delay);
	endproperty
	a_lor_delay: assert property (p_lor_delay) else $error("lock delay wrong");
	property p_bidir_oe;
		sdio_oe |-> cfg_o.readback_pin_disable && !serial_readback_pin_oe;
	endproperty
	a_bidir_oe: assert property (p_bidir_oe) else $error("shared pin driven wrongly");
	property p_rb_oe;
		serial_readback_pin_oe |-> !cfg_o.readback_pin_disable;
	endproperty
	a_rb_oe: assert property (p_rb_oe) else $error("readback pin not floated");
	property p_oe_quiet;
		serial_select_n [*5] |-> !sdio_oe && !serial_readback_pin_oe;
	endproperty
	a_oe_quiet: assert property (p_oe_quiet) else $error("pin driven while idle");
	property p_oe_start;
		$rose(sdio_oe) || $rose(serial_readback_pin_oe) |-> !serial_select_n;
	endproperty
	a_oe_start: assert property (p_oe_start) else $error("pin enabled outside frame");
	property p_srst_hold;
		cfg_o.soft_reset && $past(cfg_o.soft_reset) |-> cfg_o.swallow_count == 6'h00 &&
			cfg_o.feedback_count == 13'h0000 && cfg_o.cp_mode == PSCFG_CP_TRISTATE;
	endproperty
	a_srst_hold: assert property (p_srst_hold) else $error("soft reset not held");
	// Bit must survive between frames, it never clears itself
	property p_srst_sticky;
		cfg_o.soft_reset && serial_select_n |=> cfg_o.soft_reset;
	endproperty
	a_srst_sticky: assert property (p_srst_sticky) else $error("soft reset cleared");
	c_pump_down: cover property (cp_pump_down);
	c_bidir: cover property (sdio_oe);
	c_lsb_rb: cover property (cfg_o.lsb_first && serial_readback_pin_oe);
	c_srst: cover property (cfg_o.soft_reset);
endmodule

bind pscfg_top pscfg_top_asserts u_asserts (.clk_sys(clk_sys), .rst_n(rst_n),
	.serial_select_n(serial_select_n), .serial_clk(serial_clk), .sdio_i(sdio_i),
	.sdio_o(sdio_o), .sdio_oe(sdio_oe), .serial_readback_pin_o(serial_readback_pin_o),
	.serial_readback_pin_oe(serial_readback_pin_oe), .cfg_o(cfg_o),
	.ref_loss_delay_cycles(ref_loss_delay_cycles), .cp_pump_up(cp_pump_up),
	.cp_pump_down(cp_pump_down), .cp_pfd_driven(cp_pfd_driven), .cp_tristate(cp_tristate));

// file: test/pscfg_host.sv
/* Serial host model: frames of one to four bytes in the device's current bit order and length.
   Assumes clk_sys at 100 ns; serial clock runs 4 low, 4 high, only within frames. */
`timescale 1ns/100ps

module pscfg_host (
	input  logic       clk_sys,         // System clock
	output logic       serial_select_n, // Select, active low
	output logic       serial_clk,      // Serial clock
	output logic       sdio_i,          // Resolved shared wire
	input  logic       sdio_o,          // Device shared data
	input  logic       sdio_oe,         // Device drives shared pin
	input  logic       rb_o,            // Readback pin data
	input  logic       rb_oe,           // Readback pin enable
	output logic       done,            // Read byte ready
	output logic [7:0] rdv              // Read byte
);
	logic drv = 1'b0, smp = 1'b0, lng = 1'b1, lsb = 1'b0, bidir = 1'b0;
	initial begin
		serial_select_n = 1'b1;
		serial_clk = 1'b0;
		done = 1'b0;
		rdv = 8'h00;
	end
	assign sdio_i = sdio_oe ? sdio_o : drv;
	// Data changes with the fall; sampled well after the device's late update
	task automatic bit_io(input logic b);
		@(posedge clk_sys) begin
			serial_clk <= 1'b0;
			drv <= b;
		end
		repeat (3) @(posedge clk_sys);
		@(posedge clk_sys) serial_clk <= 1'b1;
		@(posedge clk_sys) #1 smp = bidir ? sdio_i : (rb_oe ? rb_o : ~rb_o);
		repeat (2) @(posedge clk_sys);
	endtask
	// Count code above zero is for writes only; a read keeps one byte
	task automatic frame(input logic rw, input logic [12:0] a, input logic [7:0] wd,
		input logic [1:0] cnt = 2'b00, input logic [7:0] wd2 = 8'h00);
		logic [15:0] ins;
		logic [7:0]  r;
		logic [7:0]  b;
		int          n;
		ins = lng ? {rw, cnt, a} : {8'h00, rw, cnt, a[4:0]};
		n = lng ? 16 : 8;
		@(posedge clk_sys) serial_select_n <= 1'b0;
		for (int i = 0; i < n; i++) bit_io(ins[lsb ? i : n - 1 - i]);
		for (int k = 0; k <= int'(cnt); k++) begin
			b = (k != 0) ? wd2 : wd;
			for (int i = 0; i < 8; i++) begin
				// Released wire toggles so a silent device never reads as valid
				bit_io(rw ? ~drv : b[lsb ? i : 7 - i]);
				r[lsb ? i : 7 - i] = smp;
			end
		end
		@(posedge clk_sys) serial_clk <= 1'b0;
		repeat (3) @(posedge clk_sys);
		@(posedge clk_sys) begin
			serial_select_n <= 1'b1;
			done <= rw;
			rdv <= r;
		end
		@(posedge clk_sys) done <= 1'b0;
		repeat (4) @(posedge clk_sys);
		if (!rw && a == 13'h0000) {bidir, lsb, lng} = {wd[7], wd[6], wd[4]};
	endtask
endmodule

// file: test/pscfg_top_test.sv
/* Self-checking bench for pscfg_top with the serial host model.
   Assumes pscfg_host and the bound checker are compiled alongside. */
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module pscfg_top_test;
	import pscfg_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        look = 1'b0;
	logic        sel_n, sclk, sdio, sd_o, sd_oe, rb_o, rb_oe, done, up, dn, pfd, tri_s;
	logic [7:0]  rdv, v;
	logic [4:0]  dly;
	logic [31:0] q[$];
	logic [31:0] e;
	logic [7:0]  w[9];
	logic [7:0]  mk[9] = '{8'hF0, 8'h00, 8'h00, 8'h00, 8'h3F, 8'h1F, 8'hFF, 8'h64, 8'h03};
	logic [3:0]  oh[4] = '{4'h1, 4'h8, 4'h4, 4'h2};
	pscfg_cfg_t  cfg;
	int          n_fail = 0;
	int          n_compared = 0;
	always #50 clk_sys = ~clk_sys;
	pscfg_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .serial_select_n(sel_n),
		.serial_clk(sclk), .sdio_i(sdio), .sdio_o(sd_o), .sdio_oe(sd_oe),
		.serial_readback_pin_o(rb_o), .serial_readback_pin_oe(rb_oe), .cfg_o(cfg),
		.ref_loss_delay_cycles(dly), .cp_pump_up(up), .cp_pump_down(dn),
		.cp_pfd_driven(pfd), .cp_tristate(tri_s));
	pscfg_host h (.clk_sys(clk_sys), .serial_select_n(sel_n), .serial_clk(sclk),
		.sdio_i(sdio), .sdio_o(sd_o), .sdio_oe(sd_oe), .rb_o(rb_o), .rb_oe(rb_oe),
		.done(done), .rdv(rdv));
	wire [31:0] obs = look ? {up, dn, pfd, tri_s, dly, cfg.swallow_count,
		cfg.feedback_count, cfg.ref_loss_enable, 3'h0} : {24'h00_0000, rdv};
	always @(posedge clk_sys) if (done || look) begin
		e = q.pop_front();
		`CHK(obs, e)
	end
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		h.frame(1'b0, a, d);
	endtask
	task automatic rd_chk(input logic [12:0] a, input logic [7:0] x);
		q.push_back({24'h00_0000, x});
		h.frame(1'b1, a, 8'h00);
	endtask
	task automatic peek(input logic [31:0] x);
		q.push_back(x);
		@(posedge clk_sys) look <= 1'b1;
		@(posedge clk_sys) look <= 1'b0;
	endtask
	task automatic results;
		if (q.size() != 0) n_fail++;
		if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		void'($urandom(70545));
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		for (int a = 0; a < 10; a++) rd_chk(13'(a), a ? 8'h00 : 8'h10);
		for (int a = 1; a < 9; a++) begin
			w[a] = 8'($urandom);
			wr(13'(a), w[a]);
			rd_chk(13'(a), w[a] & mk[a]);
		end
		for (int i = 0; i < 4; i++) begin
			wr(13'h0007, {1'b0, 2'(i), 5'h04});
			wr(13'h0008, 8'(i));
			peek({oh[i], 5'(3 << i), w[4][5:0], w[5][4:0], w[6], 4'h8});
		end
		wr(13'h0000, 8'h30);
		for (int a = 4; a < 9; a++) rd_chk(13'(a), 8'h00);
		rd_chk(13'h0000, 8'h30);
		wr(13'h0000, 8'h10);
		wr(13'h0004, 8'h2A);
		rd_chk(13'h0004, 8'h2A);
		h.frame(1'b0, 13'h0005, 8'h0A, 2'b01, 8'h15);
		rd_chk(13'h0005, 8'h0A);
		rd_chk(13'h0004, 8'h15);
		v = 8'($urandom);
		wr(13'h0000, 8'h50);
		wr(13'h0006, v);
		rd_chk(13'h0006, v);
		h.frame(1'b0, 13'h0004, 8'h2B, 2'b01, 8'h11);
		rd_chk(13'h0004, 8'h2B);
		rd_chk(13'h0005, 8'h11);
		rd_chk(13'h0000, 8'h50);
		wr(13'h0000, 8'hD0);
		rd_chk(13'h0006, v);
		wr(13'h0000, 8'h00);
		rd_chk(13'h0006, v);
		rd_chk(13'h0000, 8'h00);
		results();
	end
	// About 1.2 ms of frames expected
	initial begin
		#5_000_000;
		n_fail++;
		results();
	end
endmodule
